// ### pkg/ulms_pkg.sv
// Purpose: Shared constants and types for the line and modem status block
// Assumes: Eight-bit register port, word index addressing
// Notes:   Offsets follow the usual serial port map
package ulms_pkg;

	localparam int          ULMS_AW        = 3;
	localparam int          ULMS_DW        = 8;
	// Register indices
	localparam logic [2:0]  ULMS_A_DATA    = 3'h0;
	localparam logic [2:0]  ULMS_A_IEN     = 3'h1;
	localparam logic [2:0]  ULMS_A_ISTAT   = 3'h2;
	localparam logic [2:0]  ULMS_A_LCTL    = 3'h3;
	localparam logic [2:0]  ULMS_A_MCTL    = 3'h4;
	localparam logic [2:0]  ULMS_A_LSTAT   = 3'h5;
	localparam logic [2:0]  ULMS_A_MSTAT   = 3'h6;
	localparam logic [2:0]  ULMS_A_SCR     = 3'h7;
	// Reset values
	localparam logic [7:0]  ULMS_RST_ZERO  = 8'h00;
	localparam logic [7:0]  ULMS_RST_ISTAT = 8'h01;
	localparam logic [7:0]  ULMS_RST_LSTAT = 8'h60;
	localparam logic [7:0]  ULMS_RST_SCR   = 8'hff;
	localparam logic [3:0]  ULMS_NIB_ZERO  = 4'h0;
	// Field positions
	localparam int          ULMS_LS_DR     = 0;
	localparam int          ULMS_LS_OE     = 1;
	localparam int          ULMS_LS_PE     = 2;
	localparam int          ULMS_LS_FE     = 3;
	localparam int          ULMS_LS_BI     = 4;
	localparam int          ULMS_LS_THE    = 5;
	localparam int          ULMS_LS_TEMT   = 6;
	localparam int          ULMS_IE_LINE   = 2;
	localparam int          ULMS_IE_MODEM  = 3;
	localparam int          ULMS_MC_TREADY = 0;
	localparam int          ULMS_MC_RSEND  = 1;
	localparam int          ULMS_MC_AUX1   = 2;
	localparam int          ULMS_MC_AUX2   = 3;
	localparam int          ULMS_MC_LOOP   = 4;
	// Interrupt source codes
	localparam logic [3:0]  ULMS_IS_NONE   = 4'h1;
	localparam logic [3:0]  ULMS_IS_LINE   = 4'h6;
	localparam logic [3:0]  ULMS_IS_MODEM  = 4'h0;

	// Modem inputs as seen on the pins, active low
	typedef struct packed {
		logic cd_n;
		logic ri_n;
		logic dsr_n;
		logic cts_n;
	} ulms_modem_t;

	// Receive character tags offered by the receiver
	typedef struct packed {
		logic brk;
		logic frame;
		logic parity;
	} ulms_rx_tag_t;

	// Transmitter state reported by the transmit path
	typedef struct packed {
		logic hold_to_shift;
		logic shift_busy;
	} ulms_tx_evt_t;

endpackage

// ### logic/ulms_sync.sv
// Purpose: Two stage synchroniser for a bundle of pin levels
// Assumes: Inputs are asynchronous to clk_sys
// Notes:   First stage feeds only the second stage
`timescale 1ns/10ps
`default_nettype none
module ulms_sync #(
	parameter int W = 4
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);

	logic [W-1:0] meta_ff;

	// No reset on purpose: the stages keep tracking the pins during reset,
	// so levels are already valid at release and no false delta follows
	always_ff @(posedge clk_sys) begin
		meta_ff <= d_in;
		q_out   <= meta_ff;
	end

endmodule // ulms_sync
`default_nettype wire

// ### logic/ulms_modem.sv
// Purpose: Modem status deltas and levels with loopback remap
// Assumes: Synchronised active-low inputs
// Notes:   Deltas are sticky until a modem status read
`timescale 1ns/10ps
`default_nettype none
module ulms_modem
	import ulms_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        rst,
	input  wire ulms_modem_t pins,
	input  wire logic [3:0]  mctl_lo,
	input  wire logic        loop_en,
	input  wire logic        rd_clear,
	output var  logic [7:0]  mstat
);

	logic [3:0] lvl_ff;
	logic       seeded_ff;
	logic [3:0] deltas_ff;
	logic [3:0] lvl_now;
	logic [3:0] chg;
	logic [3:0] nxt_deltas;

	// pin levels inverted; loopback remap cts,dsr,ri,cd
	assign lvl_now = loop_en ? {mctl_lo[ULMS_MC_AUX2], mctl_lo[ULMS_MC_AUX1],
	                            mctl_lo[ULMS_MC_TREADY], mctl_lo[ULMS_MC_RSEND]}
	                         : ~{pins.cd_n, pins.ri_n, pins.dsr_n, pins.cts_n};
	// any edge on cts, dsr, cd
	assign chg[0] = seeded_ff & (lvl_now[0] ^ lvl_ff[0]);
	assign chg[1] = seeded_ff & (lvl_now[1] ^ lvl_ff[1]);
	assign chg[3] = seeded_ff & (lvl_now[3] ^ lvl_ff[3]);
	// ring pin low to high means status bit falls
	assign chg[2] = seeded_ff & lvl_ff[2] & ~lvl_now[2];
	// Set wins over a read clear in the same cycle
	assign nxt_deltas = (rd_clear ? ULMS_NIB_ZERO : deltas_ff) | chg;
	assign mstat = {lvl_now, deltas_ff};

	// reset clears deltas and levels; first cycle after reset seeds levels from present inputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			deltas_ff <= ULMS_NIB_ZERO;
			lvl_ff    <= ULMS_NIB_ZERO;
			seeded_ff <= 1'b0;
		end else begin
			deltas_ff <= nxt_deltas;
			lvl_ff    <= lvl_now;
			seeded_ff <= 1'b1;
		end
	end

endmodule // ulms_modem
`default_nettype wire

// ### logic/ulms_top.sv
// Purpose: Line status, modem status, scratch and reset state of a serial port
// Assumes: Receive and transmit datapaths live outside and report events
// Notes:   Read data valid the cycle after the read strobe
//
// Functional notes
// - Parity tag set for the held character that failed parity.
// - Framing tag set for the held character lacking a stop bit.
// - Break tag set when input stayed low a whole frame.
// - Holding empty flag set when byte moves to the shift register.
// - Holding empty flag cleared on the host write to holding register.
// - Transmitter empty set when idle, low while any character held.
// - Delta flags for cts, dsr, cd set on any change since read.
// - Ring delta set only on ring input going low to high.
// - Modem interrupt raised when a delta is set and enabled.
// - Outside loopback upper modem bits are inverted input levels.
// - Loopback maps cts, dsr, ri, cd from control bits 1,0,2,3.
// - Eight-bit scratch register, all ones after reset.
// - Reset loads enable, line, modem control zero, status 01 and 60.
// - Reset clears deltas, upper bits follow inverted inputs.
// - Modem status read clears pending modem interrupt.
// - Line status read clears line interrupt; tags stay with character.
// - Modem control bit 4 enters and leaves internal loopback.
//
// Implementation choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`default_nettype none
module ulms_top
	import ulms_pkg::*;
(
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic [ULMS_AW-1:0] reg_addr,
	input  wire logic [ULMS_DW-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output var  logic [ULMS_DW-1:0] reg_rdata,
	input  wire logic              rx_load,
	input  wire ulms_rx_tag_t      rx_tags,
	input  wire logic              rx_overrun,
	input  wire ulms_tx_evt_t      tx_evt,
	input  wire logic              tx_serial,
	input  wire ulms_modem_t       modem_pins,
	output var  logic              serial_out,
	output var  logic              rts_n,
	output var  logic              dtr_n,
	output var  logic              rst_buf,
	output var  logic              irq_out,
	output var  logic              irq_oe_n,
	output var  logic [7:0]        line_ctl,
	output var  logic              thr_load
);

	logic [7:0]  ien_ff;
	logic [7:0]  lctl_ff;
	logic [7:0]  mctl_ff;
	logic [7:0]  scr_ff;
	logic        dr_ff;
	logic        oe_ff;
	logic        pe_ff;
	logic        fe_ff;
	logic        bi_ff;
	logic        the_ff;
	logic        temt_ff;
	logic        line_pend_ff;
	logic [7:0]  rdata_ff;
	logic        sout_ff;
	logic        rts_ff;
	logic        dtr_ff;
	logic        rstb_ff;
	logic        irq_ff;
	logic        irqoe_ff;
	logic        thr_load_ff;
	logic [7:0]  lctl_o_ff;
	ulms_modem_t pins_s;
	logic [7:0]  mstat;
	logic [7:0]  lstat;
	logic [7:0]  istat;
	logic [7:0]  rd_mux;
	logic        wr_data;
	logic        rd_data;
	logic        rd_lstat;
	logic        rd_mstat;
	logic        loop_en;
	logic        modem_irq;
	logic        line_irq;
	logic        any_err;
	logic        nxt_the;
	logic        nxt_temt;
	logic        nxt_pend;

	// Modem pins are asynchronous, two flops first
	ulms_sync #(
		.W(4)
	) u_sync (
		.clk_sys (clk_sys),
		.rst     (rst),
		.d_in    (modem_pins),
		.q_out   (pins_s)
	);

	ulms_modem u_modem (
		.clk_sys  (clk_sys),
		.rst      (rst),
		.pins     (pins_s),
		.mctl_lo  (mctl_ff[3:0]),
		.loop_en  (loop_en),
		.rd_clear (rd_mstat),
		.mstat    (mstat)
	);

	// Access decode
	assign wr_data  = reg_wr & (reg_addr == ULMS_A_DATA) & ~lctl_ff[7];
	assign rd_data  = reg_rd & (reg_addr == ULMS_A_DATA) & ~lctl_ff[7];
	assign rd_lstat = reg_rd & (reg_addr == ULMS_A_LSTAT);
	// modem status read clears deltas and so the interrupt
	assign rd_mstat = reg_rd & (reg_addr == ULMS_A_MSTAT);
	assign loop_en  = mctl_ff[ULMS_MC_LOOP];

	assign lstat = {1'b0, temt_ff, the_ff, bi_ff, fe_ff, pe_ff, oe_ff, dr_ff};
	assign any_err = rx_tags.parity | rx_tags.frame | rx_tags.brk | rx_overrun;

	// modem interrupt from any enabled delta
	assign modem_irq = ien_ff[ULMS_IE_MODEM] & (|mstat[3:0]);
	assign line_irq  = ien_ff[ULMS_IE_LINE] & line_pend_ff;
	// Priority: line status above modem status
	assign istat = line_irq  ? {4'h0, ULMS_IS_LINE}  :
	               modem_irq ? {4'h0, ULMS_IS_MODEM} : {4'h0, ULMS_IS_NONE};

	// Read mux; offset 0 data and divisor read zero, offset 1 reads ien_ff even with lctl_ff[7] set
	assign rd_mux = (reg_addr == ULMS_A_IEN)   ? ien_ff  :
	                (reg_addr == ULMS_A_ISTAT) ? istat   :
	                (reg_addr == ULMS_A_LCTL)  ? lctl_ff :
	                (reg_addr == ULMS_A_MCTL)  ? mctl_ff :
	                (reg_addr == ULMS_A_LSTAT) ? lstat   :
	                (reg_addr == ULMS_A_MSTAT) ? mstat   :
	                (reg_addr == ULMS_A_SCR)   ? scr_ff  : ULMS_RST_ZERO;

	// set on handover; host write clears, and wins
	assign nxt_the  = wr_data ? 1'b0 : (tx_evt.hold_to_shift | the_ff);
	// empty only when holding empty and shifter idle
	assign nxt_temt = nxt_the & ~tx_evt.shift_busy;
	// new error sets, line status read clears; set wins
	assign nxt_pend = (rx_load & any_err) | (line_pend_ff & ~rd_lstat);

	// Host writable registers, status offsets take no write
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			ien_ff  <= ULMS_RST_ZERO;
			lctl_ff <= ULMS_RST_ZERO;
			mctl_ff <= ULMS_RST_ZERO;
			scr_ff  <= ULMS_RST_SCR;
		end else if (reg_wr) begin
			if (reg_addr == ULMS_A_IEN && !lctl_ff[7])
				ien_ff <= reg_wdata;
			if (reg_addr == ULMS_A_LCTL)
				lctl_ff <= reg_wdata;
			if (reg_addr == ULMS_A_MCTL)
				mctl_ff <= reg_wdata;
			if (reg_addr == ULMS_A_SCR)
				scr_ff <= reg_wdata;
		end
	end

	// Receive tags travel with the held character
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			{dr_ff, oe_ff, pe_ff, fe_ff, bi_ff} <= 5'h00;
		end else if (rx_load) begin
			// parity tag latched with the character
			pe_ff <= rx_tags.parity;
			// framing tag latched with the character
			fe_ff <= rx_tags.frame;
			// break tag from a full low frame
			bi_ff <= rx_tags.brk;
			dr_ff <= 1'b1;
			oe_ff <= rx_overrun | oe_ff;
		end else if (rd_data) begin
			{dr_ff, pe_ff, fe_ff, bi_ff} <= 4'h0;
		end else if (rd_lstat) begin
			oe_ff <= 1'b0;
		end
	end

	// Transmit flags and line interrupt, reset value
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			the_ff       <= ULMS_RST_LSTAT[ULMS_LS_THE];
			temt_ff      <= ULMS_RST_LSTAT[ULMS_LS_TEMT];
			line_pend_ff <= 1'b0;
		end else begin
			the_ff       <= nxt_the;
			temt_ff      <= nxt_temt;
			line_pend_ff <= nxt_pend;
		end
	end

	// Registered read data, one cycle after the strobe
	always_ff @(posedge clk_sys) begin
		if (rst)
			rdata_ff <= ULMS_RST_ZERO;
		else
			rdata_ff <= reg_rd ? rd_mux : ULMS_RST_ZERO;
	end

	// Pin outputs; loopback parks modem outputs inactive
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			sout_ff     <= 1'b1;
			rts_ff      <= 1'b1;
			dtr_ff      <= 1'b1;
			rstb_ff     <= 1'b1;
			irq_ff      <= 1'b0;
			irqoe_ff    <= 1'b1;
			thr_load_ff <= 1'b0;
			lctl_o_ff   <= ULMS_RST_ZERO;
		end else begin
			sout_ff     <= loop_en ? 1'b1 : (tx_serial & ~lctl_ff[6]);
			rts_ff      <= loop_en | ~mctl_ff[ULMS_MC_RSEND];
			dtr_ff      <= loop_en | ~mctl_ff[ULMS_MC_TREADY];
			rstb_ff     <= ien_ff[5] & mctl_ff[ULMS_MC_AUX1];
			irq_ff      <= line_irq | modem_irq;
			// Interrupt pin drives only with output enable bit
			irqoe_ff    <= loop_en | ~mctl_ff[ULMS_MC_AUX2];
			thr_load_ff <= wr_data;
			lctl_o_ff   <= lctl_ff;
		end
	end

	assign reg_rdata  = rdata_ff;
	assign serial_out = sout_ff;
	assign rts_n      = rts_ff;
	assign dtr_n      = dtr_ff;
	assign rst_buf    = rstb_ff;
	assign irq_out    = irq_ff;
	assign irq_oe_n   = irqoe_ff;
	assign line_ctl   = lctl_o_ff;
	assign thr_load   = thr_load_ff;

endmodule // ulms_top
`default_nettype wire

// ### sim/ulms_top_properties.sv
// Purpose: Port level assertions for the line and modem status block
// Assumes: One clock domain, synchronous active high reset
// Notes:   Modem control is shadowed here since loopback is not visible at the ports
`timescale 1ns/10ps
`default_nettype none
module ulms_props
	import ulms_pkg::*;
(
	input  wire logic               clk_sys,
	input  wire logic               rst,
	input  wire logic [ULMS_AW-1:0] reg_addr,
	input  wire logic [ULMS_DW-1:0] reg_wdata,
	input  wire logic               reg_wr,
	input  wire logic               reg_rd,
	input  wire logic [ULMS_DW-1:0] reg_rdata,
	input  wire ulms_tx_evt_t       tx_evt,
	input  wire ulms_modem_t        modem_pins,
	input  wire logic               serial_out,
	input  wire logic               rts_n,
	input  wire logic               dtr_n,
	input  wire logic               irq_oe_n,
	input  wire logic [7:0]         line_ctl,
	input  wire logic               thr_load
);
	logic [7:0] mc_ff;
	logic [7:0] mc_q_ff;
	logic [3:0] pins_q_ff;
	wire  logic rd_lsr;
	wire  logic rd_msr;
	wire  logic rd_scr;
	wire  logic wr_scr;
	wire  logic wr_data;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// Access decode
	assign rd_lsr  = reg_rd && reg_addr == ULMS_A_LSTAT;
	assign rd_msr  = reg_rd && reg_addr == ULMS_A_MSTAT;
	assign rd_scr  = reg_rd && reg_addr == ULMS_A_SCR;
	assign wr_scr  = reg_wr && reg_addr == ULMS_A_SCR;
	assign wr_data = reg_wr && reg_addr == ULMS_A_DATA;

	// Shadow of modem control plus one cycle delayed copies
	always_ff @(posedge clk_sys) begin
		if (rst)
			mc_ff <= 8'h00;
		else if (reg_wr && reg_addr == ULMS_A_MCTL)
			mc_ff <= reg_wdata;
		mc_q_ff   <= mc_ff;
		pins_q_ff <= modem_pins;
	end

	// Pins and control quiet long enough to get through the synchroniser
	sequence quiet5;
		($stable(modem_pins) && $stable(mc_ff))[*5];
	endsequence
	sequence msr_again;
		rd_msr ##1 (rd_msr && $stable(modem_pins) && $stable(mc_ff));
	endsequence
	sequence scr_wr_rd;
		wr_scr ##1 rd_scr;
	endsequence

	chk_lsr_top_zero: assert property (rd_lsr |=> !reg_rdata[7])
		else $error("line status bit 7 read as one");
	chk_reset_pins: assert property ($fell(rst) |-> serial_out && rts_n && dtr_n && irq_oe_n && line_ctl == 8'h00)
		else $error("pins not at reset level after reset");
	chk_thr_clear: assert property ((wr_data && !line_ctl[7]) ##1 (rd_lsr && !tx_evt.hold_to_shift) |=> !reg_rdata[5])
		else $error("holding empty still set after data write");
	chk_temt_busy: assert property (rd_lsr && tx_evt.shift_busy && $past(tx_evt.shift_busy) |=> !reg_rdata[6])
		else $error("transmitter empty while shifter busy");
	chk_loop_map: assert property (rd_msr && mc_ff[4] && $stable(mc_ff) |=> reg_rdata[7:4] == {mc_q_ff[3], mc_q_ff[2], mc_q_ff[0], mc_q_ff[1]})
		else $error("loopback levels do not follow modem control");
	chk_pin_level: assert property (quiet5 ##0 (rd_msr && !mc_ff[4]) |=> reg_rdata[7:4] == ~pins_q_ff)
		else $error("modem levels not inverted pins");
	chk_delta_clear: assert property (quiet5 ##0 msr_again |=> reg_rdata[3:0] == 4'h0)
		else $error("delta flags set without a pin change");
	chk_scr_rw: assert property (scr_wr_rd |=> reg_rdata == $past(reg_wdata, 2))
		else $error("scratch read back differs");
	chk_thr_pulse: assert property (thr_load |-> $past(wr_data))
		else $error("holding load pulse without a data write");
endmodule // ulms_props
`default_nettype wire

// ### sim/ulms_host.sv
// Purpose: Host processor model on the register port
// Assumes: Strobes are taken on the rising edge of clk_sys
// Notes:   Strobes stay up until the next call so accesses run back to back
`timescale 1ns/10ps
`default_nettype none
module ulms_host
	import ulms_pkg::*;
(
	input  wire logic               clk_sys,
	output var  logic [ULMS_AW-1:0] reg_addr,
	output var  logic [ULMS_DW-1:0] reg_wdata,
	output var  logic               reg_wr,
	output var  logic               reg_rd,
	input  wire logic [ULMS_DW-1:0] reg_rdata
);
	logic               rd_seen_ff = 1'b0;
	logic [ULMS_DW-1:0] got_ff = 8'h00;

	// Bus idle at time zero
	initial begin
		reg_addr = 3'h0;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end

	// Read data stands one cycle only, so catch it at the edge that closes that cycle
	always @(posedge clk_sys) begin
		rd_seen_ff <= reg_rd;
		if (rd_seen_ff)
			got_ff <= reg_rdata;
	end

	task automatic op(input logic w, input logic r, input logic [ULMS_AW-1:0] a, input logic [ULMS_DW-1:0] d);
		@(posedge clk_sys);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
	endtask

	// Drop the strobes and hand back the last read data
	task automatic fin(output logic [ULMS_DW-1:0] d);
		op(1'b0, 1'b0, reg_addr, reg_wdata);
		@(posedge clk_sys);
		#1 d = got_ff;
	endtask
endmodule // ulms_host
`default_nettype wire

// ### sim/tb_ulms_top.sv
// Purpose: Self-checking bench for the line and modem status block
// Assumes: Host model owns the register port
// Notes:   Pin changes get six cycles to clear the synchroniser
`timescale 1ns/10ps
`default_nettype none
module tb_ulms_top
	import ulms_pkg::*;
;
	logic               clk_sys = 1'b0;
	logic               rst = 1'b1;
	logic [ULMS_AW-1:0] reg_addr;
	logic [ULMS_DW-1:0] reg_wdata;
	logic               reg_wr, reg_rd;
	logic [ULMS_DW-1:0] reg_rdata;
	logic               rx_load = 1'b0;
	ulms_rx_tag_t       rx_tags = '0;
	ulms_tx_evt_t       tx_evt = '0;
	ulms_modem_t        modem_pins = 4'hf;
	logic               serial_out, rts_n, dtr_n, rst_buf, irq_out, irq_oe_n, thr_load;
	logic [7:0]         line_ctl, got;
	int                 num_errors = 0;
	int                 checked = 0;
	logic [7:0]         rst_tab [8] = '{8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h60, 8'h00, 8'hff};
	logic [3:0]         pin_tab [5] = '{4'he, 4'ha, 4'he, 4'h0, 4'hf};
	logic [7:0]         msr_tab [5] = '{8'h11, 8'h50, 8'h14, 8'hfa, 8'h0f};
	logic [7:0]         lp_tab [4] = '{8'h20, 8'h10, 8'h40, 8'h80};

	// 200 MHz clock
	initial begin
		forever #2.5 clk_sys = ~clk_sys;
	end

	ulms_host host_u (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata));
	ulms_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_load(rx_load), .rx_tags(rx_tags), .rx_overrun(1'b0),
		.tx_evt(tx_evt), .tx_serial(1'b1), .modem_pins(modem_pins), .serial_out(serial_out), .rts_n(rts_n),
		.dtr_n(dtr_n), .rst_buf(rst_buf), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .line_ctl(line_ctl),
		.thr_load(thr_load));

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		host_u.op(1'b1, 1'b0, a, d);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] exp);
		host_u.op(1'b0, 1'b1, a, 8'h00);
		host_u.fin(got);
		chk(got, exp);
	endtask
	// Bus goes idle before pins move, so no access overlaps the change
	task automatic step(input ulms_modem_t p);
		host_u.fin(got);
		@(posedge clk_sys);
		modem_pins <= p;
		repeat (6) @(posedge clk_sys);
	endtask
	// Second back to back read must show the deltas gone
	task automatic modem_status(input logic [7:0] exp);
		rd(ULMS_A_MSTAT, exp);
		host_u.op(1'b0, 1'b1, ULMS_A_MSTAT, 8'h00);
		host_u.op(1'b0, 1'b1, ULMS_A_MSTAT, 8'h00);
		host_u.fin(got);
		chk(got, {exp[7:4], 4'h0});
	endtask
	// Let levels settle, flush deltas, then read
	task automatic msr_fresh(input logic [7:0] exp);
		repeat (3) host_u.fin(got);
		host_u.op(1'b0, 1'b1, ULMS_A_MSTAT, 8'h00);
		host_u.fin(got);
		rd(ULMS_A_MSTAT, exp);
	endtask
	task automatic do_reset;
		host_u.fin(got);
		@(posedge clk_sys);
		rst <= 1'b1;
		repeat (8) @(posedge clk_sys);
		chk({3'h0, rst_buf, serial_out, rts_n, dtr_n, irq_oe_n}, 8'h1f);
		rst <= 1'b0;
	endtask
	task automatic tally_and_finish;
		if (num_errors == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Watchdog, far beyond the few hundred cycles the tests need
	initial begin
		#20000;
		num_errors++;
		tally_and_finish();
	end

	// Main sequence
	initial begin
		do_reset();
		for (int i = 0; i < 8; i++)
			rd(3'(i), rst_tab[i]);
		wr(ULMS_A_LSTAT, 8'hff);
		wr(ULMS_A_MSTAT, 8'hff);
		rd(ULMS_A_LSTAT, 8'h60);
		rd(ULMS_A_MSTAT, 8'h00);
		wr(ULMS_A_SCR, 8'ha5);
		rd(ULMS_A_SCR, 8'ha5);
		wr(ULMS_A_LCTL, 8'h1b);
		rd(ULMS_A_LCTL, 8'h1b);
		chk(line_ctl, 8'h1b);
		// Active pins across reset must show as levels, not as deltas
		wr(ULMS_A_SCR, 8'h5a);
		modem_pins <= 4'h0;
		do_reset();
		rd(ULMS_A_SCR, 8'hff);
		rd(ULMS_A_LCTL, 8'h00);
		rd(ULMS_A_MSTAT, 8'hf0);
		step(4'hf);
		msr_fresh(8'h00);
		// Receive tags stay until the character is read out
		for (int i = 0; i < 3; i++) begin
			@(posedge clk_sys);
			rx_load <= 1'b1;
			rx_tags <= ulms_rx_tag_t'(3'h1 << i);
			@(posedge clk_sys);
			rx_load <= 1'b0;
			rd(ULMS_A_LSTAT, 8'h61 | (8'h04 << i));
			rd(ULMS_A_LSTAT, 8'h61 | (8'h04 << i));
			rd(ULMS_A_DATA, 8'h00);
			rd(ULMS_A_LSTAT, 8'h60);
		end
		// receive side back to idle, no tags offered
		@(posedge clk_sys);
		rx_tags <= '0;
		wr(ULMS_A_DATA, 8'h41);
		rd(ULMS_A_LSTAT, 8'h00);
		@(posedge clk_sys);
		tx_evt <= 2'b11;
		@(posedge clk_sys);
		tx_evt <= 2'b01;
		rd(ULMS_A_LSTAT, 8'h20);
		@(posedge clk_sys);
		tx_evt <= 2'b00;
		rd(ULMS_A_LSTAT, 8'h60);
		for (int i = 0; i < 5; i++) begin
			step(pin_tab[i]);
			modem_status(msr_tab[i]);
		end
		wr(ULMS_A_MCTL, 8'h03);
		host_u.fin(got);
		chk({6'h0, rts_n, dtr_n}, 8'h00);
		wr(ULMS_A_IEN, 8'h08);
		wr(ULMS_A_MCTL, 8'h08);
		step(4'he);
		chk({6'h0, irq_out, irq_oe_n}, 8'h02);
		rd(ULMS_A_ISTAT, 8'h00);
		rd(ULMS_A_MSTAT, 8'h11);
		chk({6'h0, irq_out, irq_oe_n}, 8'h00);
		rd(ULMS_A_ISTAT, 8'h01);
		wr(ULMS_A_IEN, 8'h00);
		step(4'hf);
		for (int i = 0; i < 4; i++) begin
			wr(ULMS_A_MCTL, 8'h10 | (8'h01 << i));
			msr_fresh(lp_tab[i]);
		end
		wr(ULMS_A_MCTL, 8'h00);
		msr_fresh(8'h00);
		tally_and_finish();
	end
endmodule // tb_ulms_top

bind ulms_top ulms_props chk_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_evt(tx_evt), .modem_pins(modem_pins),
	.serial_out(serial_out), .rts_n(rts_n), .dtr_n(dtr_n), .irq_oe_n(irq_oe_n), .line_ctl(line_ctl),
	.thr_load(thr_load));
`default_nettype wire
